// file: hdl/melter_regs.svh
// Register map, field positions, reset values and timing counts
`ifndef MELTER_REGS_SVH
`define MELTER_REGS_SVH
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_ZONES     12'h008
`define OFS_EVT_STAT  12'h00c
`define OFS_EVT_CLR   12'h010
`define OFS_EVT_EN    12'h014
`define OFS_WINDOW    12'h018
`define CTRL_AUTOSTART 0
`define CTRL_SECONDARY 1
`define CTRL_LOC_HEAT  2
`define CTRL_LOC_SETBK 3
`define CTRL_LOC_PUMP  4
`define CTRL_ALARM     5
`define CTRL_DRUM_LOW  6
`define CTRL_DRUM_EMPTY 7
`define CTRL_XOVER     8
`define CTRL_RESET     32'h0000_0000
`define WINDOW_RESET   16'h000a
`define DEBOUNCE_NS    1000000
`define CLK_NS         50
`define DEBOUNCE_CYC   (`DEBOUNCE_NS / `CLK_NS)
`define EVT_NUM        4
`define EVT_TAKE_ON    0
`define EVT_ACTIVE     1
`define EVT_ALARM      2
`define EVT_TAKE_OFF   3
`define REQ_HEAT       0
`define REQ_SETBK      1
`define REQ_PUMP       2
`define REQ_TAKEOVER   3
`define REQ_NUM        4
`define ST_PINS        0
`define ST_RAW_TAKEOVER 4
`define ST_HEAT        5
`define ST_SETBK       6
`define ST_PUMP        7
`define ST_AIR         8
`define ST_TAKEOVER    9
`define ST_HSTATE      10
`define SOAK_CYC_DEF   8192
`endif

// file: hdl/melter_pkg.sv
// Types shared by the melter I/O block
package melter_pkg;
    typedef enum logic [1:0] {
        HS_OFF, HS_WARM_UP, HS_HEAT_SOAK, HS_ACTIVE
    } heat_state_t;
    typedef struct packed {
        logic takeover;
        logic pump;
        logic setback;
        logic heat;
    } request_t;
    typedef struct packed {
        logic err_hi;
        logic err_lo;
        logic run_hi;
        logic run_lo;
    } status_out_t;
endpackage

// file: hdl/melter_plc_io_status.sv
// Discrete controller I/O, run/error status and heat interlocks
// Operation
// R1: While takeover is held, local operator display commands are ignored.
// R2: Under takeover, automatic crossover is off; the controller commands it.
// R3: Four requests (heat, setback, pump, takeover); takeover only on primary.
// R4: Heat request turns heaters on, setback request enables setback.
// R5: Each unit drives run low, run high, error low, error high outputs.
// R6: Error code 00 ok, 01 drum low, 10 drum empty, 11 alarm.
// R7: Run code 00 off/off, 01 heat on, 10 at temp, 11 pump on at temp.
// R8: Outputs are inactive at reset and active only while their cause holds.
// R9: With autostart enabled, pump starts once all zones reach setpoint; here it starts only in active state with all zones in window.
// R10: Air motor is locked out until all zones sit inside the window.
// R11: The controller does not pump before the unit reaches active state.
// R12: Heating shows warm-up, then heat-soak at setpoint, then active.
// R13: Requests are debounced so one transition gives one state change.
`include "melter_regs.svh"

module melter_plc_io_status #(
    parameter int ZONES        = 12,
    parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
    parameter int SOAK_CYC     = `SOAK_CYC_DEF
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire melter_pkg::request_t     request_in,
    input  wire logic [ZONES-1:0]         zone_at_setpoint,
    input  wire logic [ZONES-1:0]         zone_in_window,
    output melter_pkg::status_out_t       status_out,
    output logic                          heater_on,
    output logic                          setback_on,
    output logic                          pump_on,
    output logic                          air_motor_enable,
    output logic                          auto_crossover_en,
    output logic                          crossover_cmd,
    output logic                          irq
);
    logic [31:0]              ctrl_q;
    logic [15:0]              window_q;
    logic [`EVT_NUM-1:0]      evt_stat_q;
    logic [`EVT_NUM-1:0]      evt_en_q;
    logic [`REQ_NUM-1:0]      req_sync1_q;
    logic [`REQ_NUM-1:0]      req_sync2_q;
    logic [`REQ_NUM-1:0]      req_db_q;
    logic [`REQ_NUM-1:0]      req_db_prev_q;
    logic [31:0]              db_cnt_q [`REQ_NUM];
    logic [31:0]              soak_cnt_q;
    melter_pkg::heat_state_t  hstate_q;
    melter_pkg::status_out_t  status_d;
    logic                     takeover;
    logic                     heat_cmd;
    logic                     setback_cmd;
    logic                     pump_cmd;
    logic                     all_setpoint;
    logic                     all_window;
    logic                     wr_en;
    logic [`EVT_NUM-1:0]      evt_set;
    logic [`EVT_NUM-1:0]      evt_clr;
    logic                     req_heat;
    logic                     req_setback;
    logic                     req_pump;
    logic                     req_takeover;
    logic                     takeover_rise;
    logic                     takeover_fall;
    logic                     alarm_now;
    logic                     alarm_prev;
    logic [31:0]              status_word;

    // Two-flop synchroniser; only the second stage feeds the filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_sync1_q <= '0;
            req_sync2_q <= '0;
        end else begin
            req_sync1_q <= request_in;
            req_sync2_q <= req_sync1_q;
        end
    end

    // Filter holds the old level until the new one is stable for the period
    genvar gi;
    generate
        for (gi = 0; gi < `REQ_NUM; gi++) begin : g_db
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    db_cnt_q[gi] <= 32'h0;
                    req_db_q[gi] <= 1'b0;
                end else if (req_sync2_q[gi] == req_db_q[gi]) begin
                    db_cnt_q[gi] <= 32'h0;
                end else if (db_cnt_q[gi] >= 32'(DEBOUNCE_CYC - 1)) begin
                    db_cnt_q[gi] <= 32'h0;
                    req_db_q[gi] <= req_sync2_q[gi]; // see R13
                end else begin
                    db_cnt_q[gi] <= db_cnt_q[gi] + 32'h1;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_db_prev_q <= '0;
        end else begin
            req_db_prev_q <= req_db_q;
        end
    end

    // Named views of the filtered request levels
    assign req_heat     = req_db_q[`REQ_HEAT];
    assign req_setback  = req_db_q[`REQ_SETBK];
    assign req_pump     = req_db_q[`REQ_PUMP];
    assign req_takeover = req_db_q[`REQ_TAKEOVER];

    // Secondary units ignore their own takeover input
    assign takeover = req_takeover & ~ctrl_q[`CTRL_SECONDARY]; // see R3

    // Local display commands only count while no takeover is held
    always_comb begin
        if (takeover) begin
            heat_cmd    = req_heat; // see R4
            setback_cmd = req_setback; // see R4
            pump_cmd    = req_pump;
        end else begin
            heat_cmd    = ctrl_q[`CTRL_LOC_HEAT]; // see R1
            setback_cmd = ctrl_q[`CTRL_LOC_SETBK];
            pump_cmd    = ctrl_q[`CTRL_LOC_PUMP];
        end
    end

    assign all_setpoint = &zone_at_setpoint;
    assign all_window   = &zone_in_window;

    // Heat sequence: warm-up, soak once at setpoint, then active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hstate_q   <= melter_pkg::HS_OFF;
            soak_cnt_q <= 32'h0;
        end else if (!heat_cmd) begin
            hstate_q   <= melter_pkg::HS_OFF;
            soak_cnt_q <= 32'h0;
        end else begin
            case (hstate_q)
                melter_pkg::HS_OFF: begin
                    hstate_q <= melter_pkg::HS_WARM_UP; // see R12
                end
                melter_pkg::HS_WARM_UP: begin
                    soak_cnt_q <= 32'h0;
                    if (all_setpoint) begin
                        hstate_q <= melter_pkg::HS_HEAT_SOAK; // see R12
                    end
                end
                melter_pkg::HS_HEAT_SOAK: begin
                    if (!all_setpoint) begin
                        hstate_q <= melter_pkg::HS_WARM_UP;
                    end else if (soak_cnt_q >= 32'(SOAK_CYC - 1)) begin
                        hstate_q <= melter_pkg::HS_ACTIVE; // see R12
                    end else begin
                        soak_cnt_q <= soak_cnt_q + 32'h1;
                    end
                end
                default: begin
                    if (!all_setpoint) begin
                        hstate_q <= melter_pkg::HS_WARM_UP;
                    end
                end
            endcase
        end
    end

    // Heater and setback follow the selected command source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heater_on  <= 1'b0;
            setback_on <= 1'b0;
        end else begin
            heater_on  <= heat_cmd; // see R4
            setback_on <= setback_cmd; // see R4
        end
    end

    // Air stays locked out while any zone is outside its window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            air_motor_enable <= 1'b0;
        end else begin
            air_motor_enable <= heat_cmd & all_window; // see R10
        end
    end

    // Pump is held off before active so air never reaches a cold pump;
    // a dropped heat command stops it on the same edge as the heaters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_on <= 1'b0;
        end else if (!heat_cmd || !all_window
                     || hstate_q != melter_pkg::HS_ACTIVE) begin
            pump_on <= 1'b0; // see R11
        end else begin
            pump_on <= pump_cmd
                | (ctrl_q[`CTRL_AUTOSTART] & all_setpoint); // see R9
        end
    end

    // Crossover is local automatic unless the controller has taken over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_crossover_en <= 1'b0;
        end else begin
            auto_crossover_en <= ~takeover; // see R2
        end
    end

    // Under takeover only the controller's command may swap units
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crossover_cmd <= 1'b0;
        end else begin
            crossover_cmd <= takeover & ctrl_q[`CTRL_XOVER]; // see R2
        end
    end

    // Status code; alarm outranks empty, which outranks low
    always_comb begin
        status_d = '0;
        if (ctrl_q[`CTRL_ALARM]) begin
            status_d.err_hi = 1'b1; // see R6
            status_d.err_lo = 1'b1;
        end else if (ctrl_q[`CTRL_DRUM_EMPTY]) begin
            status_d.err_hi = 1'b1; // see R6
        end else if (ctrl_q[`CTRL_DRUM_LOW]) begin
            status_d.err_lo = 1'b1; // see R6
        end
        if (pump_on) begin
            status_d.run_hi = 1'b1; // see R7
            status_d.run_lo = 1'b1;
        end else if (hstate_q == melter_pkg::HS_HEAT_SOAK
                     || hstate_q == melter_pkg::HS_ACTIVE) begin
            status_d.run_hi = 1'b1; // see R7
        end else if (hstate_q == melter_pkg::HS_WARM_UP) begin
            status_d.run_lo = 1'b1; // see R7
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_out <= '0; // see R8
        end else begin
            status_out <= status_d; // see R5
        end
    end

    // Events: takeover gained, reached active, alarm entered, takeover lost
    assign takeover_rise = req_takeover & ~req_db_prev_q[`REQ_TAKEOVER];
    assign takeover_fall = ~req_takeover & req_db_prev_q[`REQ_TAKEOVER];
    assign alarm_now     = status_d.err_hi & status_d.err_lo;
    assign alarm_prev    = status_out.err_hi & status_out.err_lo;

    // A secondary unit never reports edges of its ignored takeover input
    always_comb begin
        evt_set = '0;
        evt_set[`EVT_TAKE_ON] = takeover_rise & ~ctrl_q[`CTRL_SECONDARY];
        evt_set[`EVT_ACTIVE]  = (hstate_q == melter_pkg::HS_ACTIVE)
                                & ~(status_out.run_hi & status_out.run_lo);
        evt_set[`EVT_ALARM]   = alarm_now & ~alarm_prev;
        evt_set[`EVT_TAKE_OFF] = takeover_fall & ~ctrl_q[`CTRL_SECONDARY];
    end

    assign wr_en   = psel & penable & pwrite;

    always_comb begin
        evt_clr = '0;
        if (wr_en && paddr == `OFS_EVT_CLR) begin
            evt_clr = pwdata[`EVT_NUM-1:0];
        end
    end

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_stat_q <= '0;
        end else begin
            evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
        end
    end

    assign irq = |(evt_stat_q & evt_en_q);

    // Register writes take effect at the access-phase edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= `CTRL_RESET;
            evt_en_q <= '0;
            window_q <= `WINDOW_RESET;
        end else if (wr_en) begin
            if (paddr == `OFS_CTRL) begin
                ctrl_q <= pwdata;
            end else if (paddr == `OFS_EVT_EN) begin
                evt_en_q <= pwdata[`EVT_NUM-1:0];
            end else if (paddr == `OFS_WINDOW) begin
                window_q <= pwdata[15:0];
            end
        end
    end

    assign pready = 1'b1;

    // Status word: heat state, takeover, outputs, raw takeover, pin code
    always_comb begin
        status_word                    = 32'h0;
        status_word[`ST_HSTATE+:2]     = 2'(hstate_q);
        status_word[`ST_TAKEOVER]      = takeover;
        status_word[`ST_AIR]           = air_motor_enable;
        status_word[`ST_PUMP]          = pump_on;
        status_word[`ST_SETBK]         = setback_on;
        status_word[`ST_HEAT]          = heater_on;
        status_word[`ST_RAW_TAKEOVER]  = req_takeover;
        status_word[`ST_PINS+:4]       = status_out; // see R5
    end

    // Read mux; unmapped addresses answer with an error and zero data
    always_comb begin
        prdata  = 32'h0;
        pslverr = 1'b0;
        if (paddr == `OFS_CTRL) begin
            prdata = ctrl_q;
        end else if (paddr == `OFS_STATUS) begin
            prdata = status_word;
        end else if (paddr == `OFS_ZONES) begin
            prdata = 32'(zone_at_setpoint);
        end else if (paddr == `OFS_EVT_STAT) begin
            prdata = 32'(evt_stat_q);
        end else if (paddr == `OFS_EVT_CLR) begin
            prdata = 32'h0;
        end else if (paddr == `OFS_EVT_EN) begin
            prdata = 32'(evt_en_q);
        end else if (paddr == `OFS_WINDOW) begin
            prdata = {16'h0, window_q};
        end else begin
            pslverr = psel & penable;
        end
    end
endmodule

// file: tb/melter_io_properties.sv
// Port checker for the melter controller I/O block
`include "melter_regs.svh"
module melter_io_properties #(
    parameter int ZONES        = 12,
    parameter int DEBOUNCE_CYC = 4,
    parameter int SOAK_CYC     = 4
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire melter_pkg::request_t    request_in,
    input wire logic [ZONES-1:0]        zone_in_window,
    input wire melter_pkg::status_out_t status_out,
    input wire logic                    heater_on,
    input wire logic                    pump_on,
    input wire logic                    air_motor_enable,
    input wire logic                    auto_crossover_en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_ctrl;
    logic [1:0] err_code;
    assign wr_ctrl = psel && penable && pwrite && paddr == `OFS_CTRL;
    assign err_code = {status_out.err_hi, status_out.err_lo};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Alarm outranks both drum codes
    property p_err_alarm;
        wr_ctrl && pwdata[5] |-> ##[1:3] err_code == 2'b11;
    endproperty
    a_err_alarm: assert property (p_err_alarm)
        else $error("alarm code missing");
    property p_err_low;
        wr_ctrl && pwdata[7:5] == 3'b010 |-> ##[1:3] err_code == 2'b01;
    endproperty
    a_err_low: assert property (p_err_low)
        else $error("drum low code missing");
    property p_err_empty;
        wr_ctrl && pwdata[7:5] == 3'b100 |-> ##[1:3] err_code == 2'b10;
    endproperty
    a_err_empty: assert property (p_err_empty)
        else $error("drum empty code missing");
    property p_idle_nopump;
        !status_out.run_hi && !status_out.run_lo |-> !pump_on;
    endproperty
    a_idle_nopump: assert property (p_idle_nopump)
        else $error("pump on while idle");
    property p_pump_heat;
        pump_on |-> heater_on;
    endproperty
    a_pump_heat: assert property (p_pump_heat)
        else $error("pump on without heat");
    property p_air;
        air_motor_enable |-> heater_on && $past(&zone_in_window);
    endproperty
    a_air: assert property (p_air)
        else $error("air motor released early");
    property p_xover;
        !request_in.takeover [*8] |-> ##[0:2] auto_crossover_en;
    endproperty
    a_xover: assert property (p_xover)
        else $error("crossover not restored");
    property p_heat_on;
        (request_in.takeover && request_in.heat) [*8]
            |-> ##[0:2] heater_on;
    endproperty
    a_heat_on: assert property (p_heat_on)
        else $error("heat request not honoured");
    property p_heat_off;
        (request_in.takeover && !request_in.heat) [*8]
            |-> ##[0:2] !heater_on;
    endproperty
    a_heat_off: assert property (p_heat_off)
        else $error("local heat not blocked");
    c_pump: cover property (pump_on);
    c_alarm: cover property (err_code == 2'b11);
    c_air: cover property (air_motor_enable);
endmodule
bind melter_plc_io_status melter_io_properties #(.ZONES(ZONES),
    .DEBOUNCE_CYC(DEBOUNCE_CYC), .SOAK_CYC(SOAK_CYC)) u_props (.*);

// file: tb/plc_model.sv
// Model of the external controller driving the request inputs
module plc_model (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire melter_pkg::status_out_t status_out,
    input  wire melter_pkg::request_t    want,
    output melter_pkg::request_t         request_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pump held back until heat is at temperature, so no cold pumping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_in <= '0;
        end else begin
            request_in.heat <= want.heat;
            request_in.setback <= want.setback;
            request_in.takeover <= want.takeover;
            request_in.pump <= want.pump && status_out.run_hi;
        end
    end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the melter controller I/O block
`include "melter_regs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
    end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, zone_at_setpoint, zone_in_window;
    logic [31:0] pwdata, prdata, rd;
    logic        heater_on, setback_on, pump_on, air_motor_enable, err;
    logic        auto_crossover_en, crossover_cmd, irq;
    melter_pkg::request_t    request_in, want;
    melter_pkg::status_out_t status_out;
    int          n_mismatch = 0;
    int          n_compared = 0;
    melter_plc_io_status #(.DEBOUNCE_CYC(4), .SOAK_CYC(4)) dut (.*);
    plc_model plc (.*);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task test_done;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task t_reset;
        `CHK(status_out, 4'h0)
        `CHK(auto_crossover_en, 1'b1)
        apb(1'b0, `OFS_CTRL, 32'h0);
        `CHK(rd, `CTRL_RESET)
        apb(1'b0, `OFS_WINDOW, 32'h0);
        `CHK(rd[15:0], `WINDOW_RESET)
        apb(1'b0, 12'h0ff, 32'h0);
        `CHK(err, 1'b1)
    endtask
    task t_errors;
        logic [31:0] src [4] = '{32'h0, 32'h40, 32'h80, 32'he0};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_CTRL, src[i]);
            tick(3);
            `CHK(status_out[3:2], i[1:0])
            apb(1'b0, `OFS_STATUS, 32'h0);
            `CHK(rd[3:2], i[1:0])
        end
        apb(1'b1, `OFS_CTRL, 32'h0);
    endtask
    task t_plc;
        apb(1'b1, `OFS_EVT_EN, 32'h1);
        want <= 4'b1011;
        tick(12);
        `CHK(heater_on, 1'b1)
        `CHK(setback_on, 1'b1)
        `CHK(auto_crossover_en, 1'b0)
        `CHK(status_out[1:0], 2'b01)
        `CHK(air_motor_enable, 1'b0)
        `CHK(irq, 1'b1)
        apb(1'b0, `OFS_EVT_STAT, 32'h0);
        `CHK(rd[0], 1'b1)
        apb(1'b1, `OFS_CTRL, 32'h100);
        tick(2);
        `CHK(crossover_cmd, 1'b1)
        // Masking first, then clearing, so each step shows on its own
        apb(1'b1, `OFS_EVT_EN, 32'h0);
        tick(1);
        `CHK(irq, 1'b0)
        apb(1'b1, `OFS_EVT_CLR, 32'h1);
        apb(1'b1, `OFS_EVT_EN, 32'h1);
        tick(1);
        `CHK(irq, 1'b0)
        zone_at_setpoint <= '1;
        zone_in_window <= '1;
        want <= 4'b1101;
        tick(3);
        `CHK(status_out[1:0], 2'b10)
        `CHK(air_motor_enable, 1'b1)
        tick(12);
        `CHK(pump_on, 1'b1)
        `CHK(status_out[1:0], 2'b11)
        apb(1'b1, `OFS_CTRL, 32'h4);
        want <= 4'b1000;
        tick(12);
        `CHK(heater_on, 1'b0)
        `CHK(setback_on, 1'b0)
        `CHK(status_out[1:0], 2'b00)
    endtask
    task t_auto;
        want <= 4'b0000;
        apb(1'b1, `OFS_CTRL, 32'h105);
        tick(20);
        `CHK(auto_crossover_en, 1'b1)
        `CHK(crossover_cmd, 1'b0)
        `CHK(pump_on, 1'b1)
        zone_in_window <= '0;
        tick(3);
        `CHK(air_motor_enable, 1'b0)
        // Secondary unit: its own takeover input must be ignored
        apb(1'b1, `OFS_CTRL, 32'h103);
        want <= 4'b1000;
        tick(12);
        `CHK(auto_crossover_en, 1'b1)
        `CHK(crossover_cmd, 1'b0)
        `CHK(irq, 1'b0)
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd[9], 1'b0)
        `CHK(rd[4], 1'b1)
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        zone_at_setpoint = '0;
        zone_in_window = '0;
        want = '0;
        tick(20);
        presetn <= 1'b1;
        // Checks see values launched by the previous edge
        tick(2);
        t_reset;
        t_errors;
        t_plc;
        t_auto;
        test_done;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #1000000;
        n_mismatch++;
        test_done;
    end
endmodule
